// File: sim/scp_smbus_host.sv
// Behavioural SMBus controller that clocks the bus and pulls the data wire
`timescale 1ns/1ps
module scp_smbus_host (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // ==========================================================================
  // Timing
  // A quarter SCL period in core cycles; keeps SCL far below the link sampling rate
  localparam int Q = 6;

  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick();
    repeat (Q) @(negedge clk);
  endtask

  // ==========================================================================
  // Conditions
  // Start and repeated start alike: data falls while the clock is high
  task automatic start();
    sda_low = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b1;
    tick();
    scl = 1'b0;
    tick();
  endtask

  task automatic stop();
    sda_low = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b0;
    tick();
  endtask

  // ==========================================================================
  // Bits and bytes
  // Data changes only while the clock is low; the wire is sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    tick();
    scl = 1'b1;
    tick();
    r = sda;
    tick();
    scl = 1'b0;
    tick();
  endtask

  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Last byte of a read gets a not-acknowledge so the target lets go
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

// File: sim/test_smbus_config_register_port.sv
// Self-checking bench of the SMBus configuration register port
`timescale 1ns/1ps
module test_smbus_config_register_port;
  import scp_pkg::*;
  localparam logic [7:0] ID = 8'hc3; // Arbitrary identity value

  typedef struct packed {
    logic [6:0] ofs;
    logic [7:0] wd;
    logic [7:0] rd;
  } scp_row_s;

  logic            clk = 1'b0;
  logic            link_clk = 1'b0;
  logic            arst_n = 1'b0;
  logic            scl;
  logic            host_low;
  logic            sda_o;
  logic            sda_oe;
  logic            sel0 = 1'b1;
  logic            sel1 = 1'b0;
  logic            nvm_busy = 1'b0;
  wire logic [8:1][7:0] cfg;
  wire logic       sda = ~(host_low | (sda_oe & ~sda_o));
  wire logic [6:0] adr = {ADDR_FIXED, sel1, sel0};
  int              n_errors = 0;
  int              compares = 0;
  int              cycles = 0;
  logic [7:0]      d;
  logic            a;
  logic [7:0]      blk [1:5] = '{8'ha5, 8'h11, 8'h22, 8'h33, 8'h81};
  scp_row_s        rows [10] = '{'{7'h01, 8'ha5, 8'ha5}, '{7'h02, 8'h3c, 8'h3c},
    '{7'h03, 8'hf0, 8'hf0}, '{7'h04, 8'h0f, 8'h0f}, '{7'h05, 8'h81, 8'h81},
    '{7'h06, 8'h7e, 8'h7e}, '{7'h07, 8'h55, 8'h55}, '{7'h08, 8'haa, 8'haa},
    '{7'h00, ID, ID}, '{7'h09, 8'h44, 8'h00}};

  always #4 clk = ~clk;

  // Link clock free-running with an offset so its edges drift against clk
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  scp_smbus_target #(.ID_CODE(ID)) uut (
    .clk                     (clk),
    .arst_n                  (arst_n),
    .link_clk                (link_clk),
    .scl_i                   (scl),
    .sda_i                   (sda),
    .sda_o                   (sda_o),
    .sda_oe                  (sda_oe),
    .config_input_zero       (sel0),
    .config_input_one        (sel1),
    .nvm_program_in_progress (nvm_busy),
    .pll1_ref_div_low        (cfg[1]),
    .pll1_fb_div_low         (cfg[2]),
    .pll_mux_pll1_div_high   (cfg[3]),
    .pll2_ref_div_low        (cfg[4]),
    .pll2_fb_div_low         (cfg[5]),
    .vco_range_pll2_div_high (cfg[6]),
    .pll3_ref_div_low        (cfg[7]),
    .pll3_fb_div_low         (cfg[8])
  );

  scp_smbus_host u_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic head(input logic [7:0] cmd);
    u_host.start();
    u_host.put({adr, 1'b0}, a);
    chk({7'h0, a}, 8'h01);
    u_host.put(cmd, a);
    chk({7'h0, a}, 8'h01);
  endtask

  task automatic rhead();
    u_host.start();
    u_host.put({adr, 1'b1}, a);
    chk({7'h0, a}, 8'h01);
  endtask

  task automatic wr1(input logic [6:0] ofs, input logic [7:0] wd, input logic eack);
    head({1'b1, ofs});
    u_host.put(wd, a);
    chk({7'h0, a}, {7'h0, eack});
    u_host.stop();
  endtask

  task automatic rd1(input logic [6:0] ofs, input logic [7:0] exp);
    head({1'b1, ofs});
    rhead();
    u_host.get(1'b1, d);
    u_host.stop();
    chk(d, exp);
  endtask

  // Bound on the whole run; a hang shows up as one extra mismatch
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ==========================================================================
  // Sequence
  initial begin
    repeat (6) @(negedge clk);
    chk({7'h0, sda_oe}, 8'h00);
    chk({7'h0, sda_o}, 8'h00);
    for (int i = 1; i <= 8; i++) begin
      chk(cfg[i], RST_CFG[i]);
    end
    arst_n = 1'b1;
    repeat (10) @(negedge clk);
    foreach (rows[k]) begin
      wr1(rows[k].ofs, rows[k].wd, 1'b1);
      if (rows[k].ofs inside {[1:8]}) begin
        chk(cfg[rows[k].ofs], rows[k].wd);
      end
      rd1(rows[k].ofs, rows[k].rd);
    end
    // Block write with one byte past the count, which must be refused
    head(8'h02);
    u_host.put(8'h03, a);
    for (int i = 0; i < 4; i++) begin
      u_host.put(8'(8'h11 * (i + 1)), a);
      chk({7'h0, a}, {7'h0, i < 3});
    end
    u_host.stop();
    chk(cfg[4], 8'h33);
    chk(cfg[5], 8'h81);
    // Block read from offset zero; identity byte is hidden here
    head(8'h00);
    rhead();
    u_host.get(1'b0, d);
    chk(d, BLOCK_READ_COUNT);
    u_host.get(1'b0, d);
    chk(d, 8'h00);
    for (int i = 1; i <= 5; i++) begin
      u_host.get(i == 5, d);
      chk(d, blk[i]);
    end
    u_host.stop();
    // Programming cycle: reads served, write data refused
    nvm_busy = 1'b1;
    repeat (10) @(negedge clk);
    rd1(7'h18, 8'h80);
    rd1(7'h02, 8'h11);
    head(8'h04);
    rhead();
    u_host.get(1'b0, d);
    chk(d, BLOCK_READ_COUNT);
    u_host.get(1'b1, d);
    chk(d, 8'h33);
    u_host.stop();
    wr1(7'h02, 8'h99, 1'b0);
    chk(cfg[2], 8'h11);
    nvm_busy = 1'b0;
    repeat (10) @(negedge clk);
    rd1(7'h18, 8'h00);
    // Address follows the configuration inputs
    sel0 = 1'b0;
    sel1 = 1'b1;
    repeat (10) @(negedge clk);
    wr1(7'h03, 8'h5c, 1'b1);
    chk(cfg[3], 8'h5c);
    u_host.start();
    u_host.put({ADDR_FIXED, 2'b01, 1'b0}, a);
    chk({7'h0, a}, 8'h00);
    u_host.stop();
    // Second reset in mid-run restores every default
    arst_n = 1'b0;
    repeat (5) @(negedge clk);
    chk({7'h0, sda_oe}, 8'h00);
    for (int i = 1; i <= 8; i++) begin
      chk(cfg[i], RST_CFG[i]);
    end
    arst_n = 1'b1;
    repeat (10) @(negedge clk);
    rd1(7'h01, RST_PLL1_REF_DIV_LOW);
    wrap_up();
  end
endmodule

// File: src/scp_cfg_shadow.sv
// Core-clock copy of the configuration bytes, fed by a toggle handshake
`timescale 1ns/1ps
module scp_cfg_shadow (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       wr_tgl,
  input  wire logic [6:0] wr_ofs,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] pll1_ref_div_low,
  output logic      [7:0] pll1_fb_div_low,
  output logic      [7:0] pll_mux_pll1_div_high,
  output logic      [7:0] pll2_ref_div_low,
  output logic      [7:0] pll2_fb_div_low,
  output logic      [7:0] vco_range_pll2_div_high,
  output logic      [7:0] pll3_ref_div_low,
  output logic      [7:0] pll3_fb_div_low
);
  import scp_pkg::*;

  typedef struct packed {
    logic            tgl_m;
    logic            tgl_s;
    logic            tgl_d;
    logic [8:1][7:0] cfg;
  } scp_shadow_s;

  localparam scp_shadow_s SHADOW_RST = '{cfg: RST_CFG, default: '0};

  scp_shadow_s r_reg;
  scp_shadow_s r_next;
  logic        wr_edge;
  logic [3:0]  ofs_lo;

  assign wr_edge = r_reg.tgl_s ^ r_reg.tgl_d;
  assign ofs_lo  = wr_ofs[3:0];

  // ==========================================================================
  // Capture
  // Offset and data are held by the link side until its next write, which
  // lies many bus bits later, so they are stable when the edge is seen
  always_comb begin
    r_next       = r_reg;
    r_next.tgl_m = wr_tgl;
    r_next.tgl_s = r_reg.tgl_m;
    r_next.tgl_d = r_reg.tgl_s;
    if (wr_edge && wr_ofs >= OFS_PLL1_REF_DIV_LOW && wr_ofs <= OFS_PLL3_FB_DIV_LOW) begin
      r_next.cfg[ofs_lo] = wr_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= SHADOW_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign pll1_ref_div_low        = r_reg.cfg[1];
  assign pll1_fb_div_low         = r_reg.cfg[2];
  assign pll_mux_pll1_div_high   = r_reg.cfg[3];
  assign pll2_ref_div_low        = r_reg.cfg[4];
  assign pll2_fb_div_low         = r_reg.cfg[5];
  assign vco_range_pll2_div_high = r_reg.cfg[6];
  assign pll3_ref_div_low        = r_reg.cfg[7];
  assign pll3_fb_div_low         = r_reg.cfg[8];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_shadow_update: assert property (
    wr_edge && wr_ofs >= OFS_PLL1_REF_DIV_LOW && wr_ofs <= OFS_PLL3_FB_DIV_LOW
    |=> r_reg.cfg[$past(ofs_lo)] == $past(wr_data))
    else $error("shadow byte not updated by write");

endmodule

// File: src/scp_pkg.sv
// Shared constants and types of the SMBus configuration register port
package scp_pkg;

  // ==========================================================================
  // Register map
  localparam logic [6:0] OFS_IDENTITY            = 7'h00;
  localparam logic [6:0] OFS_PLL1_REF_DIV_LOW    = 7'h01;
  localparam logic [6:0] OFS_PLL1_FB_DIV_LOW     = 7'h02;
  localparam logic [6:0] OFS_PLL_MUX_PLL1_DIV_HI = 7'h03;
  localparam logic [6:0] OFS_PLL2_REF_DIV_LOW    = 7'h04;
  localparam logic [6:0] OFS_PLL2_FB_DIV_LOW     = 7'h05;
  localparam logic [6:0] OFS_VCO_RANGE_PLL2_HI   = 7'h06;
  localparam logic [6:0] OFS_PLL3_REF_DIV_LOW    = 7'h07;
  localparam logic [6:0] OFS_PLL3_FB_DIV_LOW     = 7'h08;
  localparam logic [6:0] OFS_STATUS              = 7'h18;
  localparam int unsigned BUSY_BIT               = 7;

  // ==========================================================================
  // Values after reset
  localparam logic [7:0] RST_PLL1_REF_DIV_LOW    = 8'h01;
  localparam logic [7:0] RST_PLL1_FB_DIV_LOW     = 8'h08;
  localparam logic [7:0] RST_PLL_MUX_PLL1_DIV_HI = 8'h00;
  localparam logic [7:0] RST_PLL2_REF_DIV_LOW    = 8'h1B;
  localparam logic [7:0] RST_PLL2_FB_DIV_LOW     = 8'h08;
  localparam logic [7:0] RST_VCO_RANGE_PLL2_HI   = 8'h00;
  localparam logic [7:0] RST_PLL3_REF_DIV_LOW    = 8'h77;
  localparam logic [7:0] RST_PLL3_FB_DIV_LOW     = 8'h08;
  localparam logic [8:1][7:0] RST_CFG = {
    RST_PLL3_FB_DIV_LOW, RST_PLL3_REF_DIV_LOW, RST_VCO_RANGE_PLL2_HI,
    RST_PLL2_FB_DIV_LOW, RST_PLL2_REF_DIV_LOW, RST_PLL_MUX_PLL1_DIV_HI,
    RST_PLL1_FB_DIV_LOW, RST_PLL1_REF_DIV_LOW};

  // ==========================================================================
  // Protocol
  localparam logic [4:0] ADDR_FIXED       = 5'h1A;
  localparam int unsigned CMD_SINGLE_BIT  = 7;
  localparam logic [7:0] BLOCK_READ_COUNT = 8'h1B;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_COUNT,
    ST_WDATA,
    ST_RDATA
  } scp_state_e;

endpackage

// File: src/scp_smbus_target.sv
// SMBus target with configuration register array, link domain and core copy
`timescale 1ns/1ps
module scp_smbus_target #(
  parameter logic [7:0] ID_CODE = 8'h5A // Arbitrary identity value
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       link_clk,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       config_input_zero,
  input  wire logic       config_input_one,
  input  wire logic       nvm_program_in_progress,
  output logic      [7:0] pll1_ref_div_low,
  output logic      [7:0] pll1_fb_div_low,
  output logic      [7:0] pll_mux_pll1_div_high,
  output logic      [7:0] pll2_ref_div_low,
  output logic      [7:0] pll2_fb_div_low,
  output logic      [7:0] vco_range_pll2_div_high,
  output logic      [7:0] pll3_ref_div_low,
  output logic      [7:0] pll3_fb_div_low
);
  import scp_pkg::*;

  typedef struct packed {
    scp_state_e      st;
    logic            scl_m;
    logic            scl_s;
    logic            scl_d;
    logic            sda_m;
    logic            sda_s;
    logic            sda_d;
    logic            cz_m;
    logic            cz_s;
    logic            co_m;
    logic            co_s;
    logic            busy_m;
    logic            busy_s;
    logic [3:0]      bitcnt;
    logic [7:0]      shift;
    logic            in_ack;
    logic            sda_oe;
    logic            single;
    logic            rd_count;
    logic [6:0]      ptr;
    logic [7:0]      remain;
    logic [8:1][7:0] regs;
    logic            wr_tgl;
    logic [6:0]      wr_ofs;
    logic [7:0]      wr_data;
  } scp_link_s;

  // SCL and SDA stages start at the idle bus level so no false edge follows reset
  localparam scp_link_s LINK_RST = '{st: ST_IDLE, regs: RST_CFG,
                                     scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1,
                                     sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1,
                                     default: '0};

  scp_link_s   r_reg;
  scp_link_s   r_next;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic        addr_match;
  logic        accept;
  logic        writable;
  logic [7:0]  rd_byte;
  logic [3:0]  ptr_lo;
  logic        busy_l;
  logic        shift_msb;
  logic        shift_b6;
  logic [6:0]  shift_ofs;

  // ==========================================================================
  // Read path
  function automatic logic [7:0] rd_value(input logic [6:0]      ofs,
                                          input logic            single,
                                          input logic            busy,
                                          input logic [8:1][7:0] regs);
    logic [7:0] v;
    v = 8'h00;
    if (ofs == OFS_IDENTITY) begin
      v = single ? ID_CODE : 8'h00;
    end else if (ofs <= OFS_PLL3_FB_DIV_LOW) begin
      v = regs[ofs[3:0]];
    end else if (ofs == OFS_STATUS) begin
      v[BUSY_BIT] = busy;
    end
    return v;
  endfunction

  // ==========================================================================
  // Bus events
  // Edges are taken from the second and third stages only
  assign scl_rise   = r_reg.scl_s & ~r_reg.scl_d;
  assign scl_fall   = ~r_reg.scl_s & r_reg.scl_d;
  assign start_cond = r_reg.scl_s & r_reg.scl_d & r_reg.sda_d & ~r_reg.sda_s;
  assign stop_cond  = r_reg.scl_s & r_reg.scl_d & ~r_reg.sda_d & r_reg.sda_s;
  assign addr_match = r_reg.shift[7:1] == {ADDR_FIXED, r_reg.co_s, r_reg.cz_s};
  assign writable   = r_reg.ptr >= OFS_PLL1_REF_DIV_LOW && r_reg.ptr <= OFS_PLL3_FB_DIV_LOW
                      && !r_reg.busy_s;
  assign rd_byte    = r_reg.rd_count ? BLOCK_READ_COUNT
                      : rd_value(r_reg.ptr, r_reg.single, r_reg.busy_s, r_reg.regs);
  assign ptr_lo     = r_reg.ptr[3:0];
  assign busy_l     = r_reg.busy_s;
  assign shift_msb  = r_reg.shift[CMD_SINGLE_BIT];
  assign shift_b6   = r_reg.shift[6];
  assign shift_ofs  = r_reg.shift[6:0];

  always_comb begin
    accept = 1'b1;
    case (r_reg.st)
      ST_ADDR:  accept = addr_match;
      // Writes during programming are refused with NACK, never half applied
      ST_WDATA: accept = !r_reg.busy_s && r_reg.remain != 8'h00;
      default:  accept = 1'b1;
    endcase
  end

  // ==========================================================================
  // Protocol engine
  always_comb begin
    r_next        = r_reg;
    r_next.scl_m  = scl_i;
    r_next.scl_s  = r_reg.scl_m;
    r_next.scl_d  = r_reg.scl_s;
    r_next.sda_m  = sda_i;
    r_next.sda_s  = r_reg.sda_m;
    r_next.sda_d  = r_reg.sda_s;
    r_next.cz_m   = config_input_zero;
    r_next.cz_s   = r_reg.cz_m;
    r_next.co_m   = config_input_one;
    r_next.co_s   = r_reg.co_m;
    r_next.busy_m = nvm_program_in_progress;
    r_next.busy_s = r_reg.busy_m;
    if (start_cond) begin
      // A repeated start keeps the command offset for the read that follows
      r_next.st     = ST_ADDR;
      r_next.bitcnt = 4'h0;
      r_next.in_ack = 1'b0;
      r_next.sda_oe = 1'b0;
    end else if (stop_cond) begin
      r_next.st     = ST_IDLE;
      r_next.in_ack = 1'b0;
      r_next.sda_oe = 1'b0;
    end else if (r_reg.st != ST_IDLE) begin
      if (scl_rise) begin
        if (r_reg.in_ack && r_reg.st != ST_RDATA) begin
          case (r_reg.st)
            ST_ADDR: begin
              if (r_reg.shift[0]) begin
                r_next.st       = ST_RDATA;
                r_next.rd_count = ~r_reg.single;
              end else begin
                r_next.st = ST_CMD;
              end
            end
            ST_CMD: begin
              r_next.single = r_reg.shift[CMD_SINGLE_BIT];
              r_next.ptr    = r_reg.shift[6:0];
              r_next.remain = 8'h01;
              r_next.st     = r_reg.shift[CMD_SINGLE_BIT] ? ST_WDATA : ST_COUNT;
            end
            ST_COUNT: begin
              r_next.remain = r_reg.shift;
              r_next.st     = ST_WDATA;
            end
            ST_WDATA: begin
              if (writable) begin
                r_next.regs[ptr_lo] = r_reg.shift;
                r_next.wr_tgl       = ~r_reg.wr_tgl;
                r_next.wr_ofs       = r_reg.ptr;
                r_next.wr_data      = r_reg.shift;
              end
              r_next.ptr    = r_reg.ptr + 7'h01;
              r_next.remain = r_reg.remain - 8'h01;
            end
            default: begin
            end
          endcase
        end else if (r_reg.st == ST_RDATA && r_reg.bitcnt == BITS_PER_BYTE) begin
          if (r_reg.sda_s) begin
            r_next.st = ST_IDLE;
          end else begin
            r_next.in_ack = 1'b1;
            if (r_reg.rd_count) begin
              r_next.rd_count = 1'b0;
            end else begin
              r_next.ptr = r_reg.ptr + 7'h01;
            end
          end
        end else if (r_reg.bitcnt < BITS_PER_BYTE) begin
          r_next.bitcnt = r_reg.bitcnt + 4'h1;
          if (r_reg.st != ST_RDATA) begin
            r_next.shift = {r_reg.shift[6:0], r_reg.sda_s};
          end
        end
      end else if (scl_fall) begin
        if (r_reg.in_ack) begin
          r_next.in_ack = 1'b0;
          r_next.bitcnt = 4'h0;
          r_next.sda_oe = 1'b0;
          if (r_reg.st == ST_RDATA) begin
            r_next.shift  = rd_byte;
            r_next.sda_oe = ~rd_byte[7];
          end
        end else if (r_reg.bitcnt == BITS_PER_BYTE) begin
          if (r_reg.st == ST_RDATA) begin
            r_next.sda_oe = 1'b0;
          end else if (accept) begin
            r_next.sda_oe = 1'b1;
            r_next.in_ack = 1'b1;
          end else begin
            r_next.st = ST_IDLE;
          end
        end else if (r_reg.st == ST_RDATA && r_reg.bitcnt != 4'h0) begin
          r_next.shift  = {r_reg.shift[6:0], 1'b0};
          r_next.sda_oe = ~r_reg.shift[6];
        end
      end
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= LINK_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Open drain: the pin is only ever pulled low
  assign sda_o  = 1'b0;
  assign sda_oe = r_reg.sda_oe;

  // ==========================================================================
  // Core-clock copy
  scp_cfg_shadow u_shadow (
    .clk                     (clk),
    .arst_n                  (arst_n),
    .wr_tgl                  (r_reg.wr_tgl),
    .wr_ofs                  (r_reg.wr_ofs),
    .wr_data                 (r_reg.wr_data),
    .pll1_ref_div_low        (pll1_ref_div_low),
    .pll1_fb_div_low         (pll1_fb_div_low),
    .pll_mux_pll1_div_high   (pll_mux_pll1_div_high),
    .pll2_ref_div_low        (pll2_ref_div_low),
    .pll2_fb_div_low         (pll2_fb_div_low),
    .vco_range_pll2_div_high (vco_range_pll2_div_high),
    .pll3_ref_div_low        (pll3_ref_div_low),
    .pll3_fb_div_low         (pll3_fb_div_low)
  );

  // ==========================================================================
  // Checks
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!arst_n);

  sequence s_byte_end;
    scl_fall && !r_reg.in_ack && r_reg.bitcnt == BITS_PER_BYTE;
  endsequence

  sequence s_ack_rise;
    scl_rise && r_reg.in_ack && !start_cond && !stop_cond;
  endsequence

  sequence s_read_load;
    scl_fall && r_reg.in_ack && r_reg.st == ST_RDATA;
  endsequence

  a_addr_reject: assert property (
    s_byte_end ##0 (r_reg.st == ST_ADDR && !addr_match) |=> !r_reg.sda_oe && r_reg.st == ST_IDLE)
    else $error("foreign address acknowledged");

  a_addr_accept: assert property (
    s_byte_end ##0 (r_reg.st == ST_ADDR && addr_match) |=> r_reg.sda_oe && r_reg.in_ack)
    else $error("own address not acknowledged");

  a_write_commit: assert property (
    s_ack_rise ##0 (r_reg.st == ST_WDATA && writable)
    |=> r_reg.regs[$past(ptr_lo)] == $past(r_reg.shift) && r_reg.wr_tgl != $past(r_reg.wr_tgl))
    else $error("byte not stored at acknowledge");

  a_busy_nack: assert property (
    s_byte_end ##0 (r_reg.st == ST_WDATA && busy_l) |=> !r_reg.sda_oe && r_reg.st == ST_IDLE)
    else $error("write acknowledged during programming");

  a_busy_flag: assert property (
    s_read_load ##0 (!r_reg.rd_count && r_reg.ptr == OFS_STATUS)
    |=> r_reg.shift[BUSY_BIT] == $past(busy_l) && r_reg.sda_oe == !$past(busy_l))
    else $error("status flag not returned");

  a_msb_first: assert property (
    scl_fall && r_reg.st == ST_RDATA && !r_reg.in_ack && r_reg.bitcnt != 4'h0
    && r_reg.bitcnt < BITS_PER_BYTE |=> r_reg.sda_oe == !$past(shift_b6))
    else $error("read bit order wrong");

  a_cmd_decode: assert property (
    s_ack_rise ##0 r_reg.st == ST_CMD
    |=> r_reg.single == $past(shift_msb) && r_reg.ptr == $past(shift_ofs)
        && r_reg.st == ($past(shift_msb) ? ST_WDATA : ST_COUNT))
    else $error("command code decoded wrongly");

  a_id_block: assert property (
    s_read_load ##0 (!r_reg.rd_count && !r_reg.single && r_reg.ptr == OFS_IDENTITY)
    |=> r_reg.shift == 8'h00)
    else $error("identity returned in block read");

  a_count_limit: assert property (
    s_byte_end ##0 (r_reg.st == ST_WDATA && r_reg.remain == 8'h00)
    |=> !r_reg.sda_oe ##1 !r_reg.sda_oe)
    else $error("byte beyond count acknowledged");

  a_block_count: assert property (
    s_read_load ##0 r_reg.rd_count |=> r_reg.shift == BLOCK_READ_COUNT)
    else $error("block read count missing");

  a_start_restart: assert property (
    start_cond |=> r_reg.st == ST_ADDR && !r_reg.sda_oe && r_reg.bitcnt == 4'h0)
    else $error("start did not restart address phase");

endmodule
